// File: common/psw_consts.svh
// Constants for the processor status word block
`ifndef PSW_CONSTS_SVH
`define PSW_CONSTS_SVH
`define PSW_ADDR 16'hFF10
`define PSW_BUS_ADDR 32'h0000FF10
`define PSW_STK_ADDR 32'h0000FF14
`define PSW_RESET 16'h0000
`define PSW_RW_MASK 16'hFC7F
`define PSW_BIT_N 0
`define PSW_BIT_C 1
`define PSW_BIT_V 2
`define PSW_BIT_Z 3
`define PSW_BIT_E 4
`define PSW_BIT_MULDIV_INTERRUPTED_FLAG 5
`define PSW_BIT_USER 6
`define PSW_BIT_HOLD 10
`define PSW_BIT_IEN 11
`define PSW_LVL_LSB 12
`define PSW_STK_MIN 16'h0020
`define PSW_STK_MAX 16'h0200
`define PSW_STK_FULL 16'h0000
`endif

// File: common/psw_pkg.sv
// Types for the processor status word block
package psw_pkg;
   typedef enum logic [1:0] {
      PSW_CLS_ARITH,
      PSW_CLS_LOGIC,
      PSW_CLS_MOVE,
      PSW_CLS_NONE
   } psw_class_t;
   typedef enum logic [1:0] {
      PSW_ST_IDLE,
      PSW_ST_ACCESS
   } psw_state_t;
endpackage

// File: core/psw_core.sv
// Processor status word register with APB access and flag update
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "psw_consts.svh"
module psw_core (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   input wire logic I_BIT_WE,
   input wire logic [3:0] I_BIT_SEL,
   input wire logic I_BIT_VAL,
   input wire logic I_ALU_VALID,
   input wire logic I_ALU_BYTE,
   input wire psw_pkg::psw_class_t I_ALU_CLASS,
   input wire logic [16:0] I_ALU_RESULT,
   input wire logic I_ALU_OVF,
   input wire logic [15:0] I_ALU_SRC,
   input wire logic I_IRQ_ENTRY,
   input wire logic [3:0] I_IRQ_LEVEL,
   input wire logic I_MULDIV_BUSY,
   input wire logic I_RETI,
   input wire logic I_RETI_MULDIV_INTERRUPTED_FLAG,
   input wire logic I_STK_PUSH,
   input wire logic I_STK_POP,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic [15:0] O_PSW,
   output logic [3:0] O_CPU_PRIORITY_LEVEL,
   output logic O_GLOBAL_IRQ_ENABLE,
   output logic O_BUS_HOLD_ARBITRATION_ENABLE,
   output logic O_USER_FLAG,
   output logic O_MULDIV_INTERRUPTED_FLAG,
   output logic [15:0] O_STACK_PTR
);
   import psw_pkg::*;

   function automatic logic [1:0] decode_addr(input logic [31:0] a);
      if (a == `PSW_BUS_ADDR)
         return 2'h1;
      else if (a == `PSW_STK_ADDR)
         return 2'h2;
      else
         return 2'h0;
   endfunction

   logic [15:0] psw_q;
   logic [15:0] psw_d;
   logic [15:0] stack_size_field_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [3:0] lvl_q;
   logic ien_q;
   logic hold_q;
   logic user_q;
   logic muldiv_interrupted_flag_q;
   logic [15:0] stk_ptr_q;
   logic [15:0] stk_ptr;
   logic [4:0] alu_flags;
   logic [15:0] wmask;
   logic setup;
   logic wr_psw;
   logic wr_stk;
   psw_state_t state_q;

   assign setup = I_PSEL && !I_PENABLE;
   // Writes take effect in the access cycle, which is also when pready is high
   assign wr_psw = (state_q == PSW_ST_ACCESS) && I_PSEL && I_PENABLE && I_PWRITE
      && (decode_addr(I_PADDR) == 2'h1);
   assign wr_stk = (state_q == PSW_ST_ACCESS) && I_PSEL && I_PENABLE && I_PWRITE
      && (decode_addr(I_PADDR) == 2'h2);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lane
         assign wmask[g*8 +: 8] = {8{I_PSTRB[g]}};
      end
   endgenerate

   psw_flag_gen u_flags (
      .i_byte(I_ALU_BYTE),
      .i_result(I_ALU_RESULT),
      .i_overflow(I_ALU_OVF),
      .i_source(I_ALU_SRC),
      .i_class(I_ALU_CLASS),
      .o_flags(alu_flags)
   );

   psw_stack_limit u_stack (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_size(stack_size_field_q),
      .i_push(I_STK_PUSH),
      .i_pop(I_STK_POP),
      .o_ptr(stk_ptr)
   );

   always_comb begin
      psw_d = psw_q;
      if (I_ALU_VALID) begin
         psw_d[4:0] = alu_flags;
      end
      if (I_IRQ_ENTRY) begin
         psw_d[15:12] = I_IRQ_LEVEL;
         psw_d[`PSW_BIT_MULDIV_INTERRUPTED_FLAG] = I_MULDIV_BUSY;
      end else if (I_RETI) begin
         psw_d[`PSW_BIT_MULDIV_INTERRUPTED_FLAG] = I_RETI_MULDIV_INTERRUPTED_FLAG;
      end
      // Explicit writes are applied last so they win over implicit updates
      if (I_BIT_WE) begin
         psw_d[I_BIT_SEL] = I_BIT_VAL;
      end
      if (wr_psw) begin
         psw_d = (psw_d & ~wmask) | (I_PWDATA[15:0] & wmask);
      end
      psw_d = psw_d & `PSW_RW_MASK;
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST)
         psw_q <= `PSW_RESET;
      else
         psw_q <= psw_d;
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST)
         stack_size_field_q <= `PSW_STK_MIN;
      // Size is clamped on write so software reads back what the pointer really uses
      else if (wr_stk) begin
         if (I_PWDATA[15:0] == `PSW_STK_FULL)
            stack_size_field_q <= `PSW_STK_FULL;
         else if (I_PWDATA[15:0] < `PSW_STK_MIN)
            stack_size_field_q <= `PSW_STK_MIN;
         else if (I_PWDATA[15:0] > `PSW_STK_MAX)
            stack_size_field_q <= `PSW_STK_MAX;
         else
            stack_size_field_q <= I_PWDATA[15:0];
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST)
         stk_ptr_q <= 16'h0000;
      else
         stk_ptr_q <= stk_ptr;
   end

   // No wait state: setup, then access with pready high
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state_q <= PSW_ST_IDLE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         case (state_q)
            PSW_ST_IDLE: begin
               pready_q <= 1'b0;
               pslverr_q <= 1'b0;
               if (setup) begin
                  state_q <= PSW_ST_ACCESS;
                  pready_q <= 1'b1;
                  pslverr_q <= (decode_addr(I_PADDR) == 2'h0);
                  case (decode_addr(I_PADDR))
                     2'h1: prdata_q <= {16'h0000, psw_q};
                     2'h2: prdata_q <= {16'h0000, stack_size_field_q};
                     default: prdata_q <= 32'h00000000;
                  endcase
               end
            end
            PSW_ST_ACCESS: begin
               state_q <= PSW_ST_IDLE;
               pready_q <= 1'b0;
               pslverr_q <= 1'b0;
            end
            default: begin
               state_q <= PSW_ST_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         lvl_q <= 4'h0;
         ien_q <= 1'b0;
         hold_q <= 1'b0;
         user_q <= 1'b0;
         muldiv_interrupted_flag_q <= 1'b0;
      end else begin
         lvl_q <= psw_d[15:12];
         ien_q <= psw_d[`PSW_BIT_IEN];
         hold_q <= psw_d[`PSW_BIT_HOLD];
         user_q <= psw_d[`PSW_BIT_USER];
         muldiv_interrupted_flag_q <= psw_d[`PSW_BIT_MULDIV_INTERRUPTED_FLAG];
      end
   end

   assign O_PRDATA = prdata_q;
   assign O_PREADY = pready_q;
   assign O_PSLVERR = pslverr_q;
   assign O_PSW = psw_q;
   assign O_CPU_PRIORITY_LEVEL = lvl_q;
   assign O_GLOBAL_IRQ_ENABLE = ien_q;
   assign O_BUS_HOLD_ARBITRATION_ENABLE = hold_q;
   assign O_USER_FLAG = user_q;
   assign O_MULDIV_INTERRUPTED_FLAG = muldiv_interrupted_flag_q;
   assign O_STACK_PTR = stk_ptr_q;
endmodule

// File: core/psw_flag_gen.sv
// Condition flag generation from an ALU or move result
`timescale 1ns/1ps
`include "psw_consts.svh"
module psw_flag_gen (
   input wire logic i_byte,
   input wire logic [16:0] i_result,
   input wire logic i_overflow,
   input wire logic [15:0] i_source,
   input wire psw_pkg::psw_class_t i_class,
   output logic [4:0] o_flags
);
   import psw_pkg::*;
   logic [15:0] res;
   logic msb;
   logic carry;
   logic zero;
   logic endt;
   always_comb begin
      res = i_result[15:0];
      msb = i_byte ? res[7] : res[15];
      carry = i_byte ? res[8] : i_result[16];
      zero = i_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
      endt = i_byte ? (i_source[7:0] == 8'h80) : (i_source == 16'h8000);
      o_flags = 5'h00;
      o_flags[`PSW_BIT_N] = msb;
      o_flags[`PSW_BIT_Z] = zero;
      if (i_class == PSW_CLS_ARITH) begin
         o_flags[`PSW_BIT_C] = carry;
         o_flags[`PSW_BIT_V] = i_overflow;
      end
      if (i_class != PSW_CLS_NONE) begin
         o_flags[`PSW_BIT_E] = endt;
      end
   end
endmodule

// File: core/psw_stack_limit.sv
// Circular system stack pointer within the dedicated area
`timescale 1ns/1ps
`include "psw_consts.svh"
module psw_stack_limit (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [15:0] i_size,
   input wire logic i_push,
   input wire logic i_pop,
   output logic [15:0] o_ptr
);
   logic [15:0] lim;
   always_comb begin
      if (i_size == `PSW_STK_FULL)
         lim = 16'hFFFF;
      else if (i_size < `PSW_STK_MIN)
         lim = `PSW_STK_MIN - 16'h0001;
      else if (i_size > `PSW_STK_MAX)
         lim = `PSW_STK_MAX - 16'h0001;
      else
         lim = i_size - 16'h0001;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst)
         o_ptr <= 16'h0000;
      else if (i_push && !i_pop)
         o_ptr <= (o_ptr >= lim) ? 16'h0000 : o_ptr + 16'h0001;
      else if (i_pop && !i_push)
         o_ptr <= (o_ptr == 16'h0000) ? lim : o_ptr - 16'h0001;
   end
endmodule

// File: tb/psw_monitor.sv
// Checker on the status word block ports
`timescale 1ns/1ps
`include "psw_consts.svh"
module psw_monitor (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [31:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   input wire logic I_BIT_WE,
   input wire logic I_ALU_VALID,
   input wire logic I_ALU_BYTE,
   input wire psw_pkg::psw_class_t I_ALU_CLASS,
   input wire logic [16:0] I_ALU_RESULT,
   input wire logic I_ALU_OVF,
   input wire logic [15:0] I_ALU_SRC,
   input wire logic I_IRQ_ENTRY,
   input wire logic [3:0] I_IRQ_LEVEL,
   input wire logic I_MULDIV_BUSY,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic [31:0] O_PRDATA,
   input wire logic [15:0] O_PSW
);
   import psw_pkg::*;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   logic wr;
   logic ok;
   assign wr = I_PSEL && I_PENABLE && I_PWRITE;
   // Implicit flags judged only where no write competes
   assign ok = I_ALU_VALID && !wr && !I_BIT_WE && !I_ALU_BYTE;
   a_reserved_zero: assert property (O_PSW[9:7] == 3'h0) else $error("reserved set");
   a_ready_next: assert property (I_PSEL && !I_PENABLE |=> O_PREADY) else $error("no ready");
   a_word_write: assert property (wr && O_PREADY && I_PADDR == `PSW_BUS_ADDR && I_PSTRB == 4'h3
      |=> O_PSW == ($past(I_PWDATA[15:0]) & `PSW_RW_MASK)) else $error("write lost");
   a_zero_logic: assert property (ok && I_ALU_CLASS == PSW_CLS_LOGIC |=> O_PSW[3:1] ==
      {$past(I_ALU_RESULT[15:0]) == 16'h0000, 2'h0}) else $error("bad zero");
   a_carry_ovf: assert property (ok && I_ALU_CLASS == PSW_CLS_ARITH |=> O_PSW[2:1] ==
      {$past(I_ALU_OVF), $past(I_ALU_RESULT[16])}) else $error("bad carry");
   a_neg_msb: assert property (ok && I_ALU_CLASS != PSW_CLS_NONE
      |=> O_PSW[0] == $past(I_ALU_RESULT[15])) else $error("bad negative");
   a_end_table: assert property (ok && I_ALU_CLASS == PSW_CLS_MOVE
      |=> O_PSW[4] == ($past(I_ALU_SRC) == 16'h8000)) else $error("bad end");
   a_irq_entry: assert property (I_IRQ_ENTRY && !wr && !I_BIT_WE |=> O_PSW[15:12] ==
      $past(I_IRQ_LEVEL) && O_PSW[5] == $past(I_MULDIV_BUSY)) else $error("bad entry");
   a_unmapped_err: assert property (O_PREADY && !I_PWRITE && I_PADDR != `PSW_BUS_ADDR
      && I_PADDR != `PSW_STK_ADDR |-> O_PSLVERR && O_PRDATA == 32'h0) else $error("no err");
   c_irq: cover property (I_IRQ_ENTRY);
   c_err: cover property (O_PSLVERR);
   c_byte: cover property (I_ALU_VALID && I_ALU_BYTE);
endmodule
bind psw_core psw_monitor u_mon (.*);

// File: tb/testbench.sv
// Self-checking bench for the status word block
`timescale 1ns/1ps
`include "psw_consts.svh"
module testbench;
   import psw_pkg::*;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, bwe = 0, bval = 0, av = 0, ab = 0;
   logic ao = 0, irq = 0, busy = 0, reti = 0, rmul = 0, push = 0, pop = 0;
   logic [31:0] pa = 0, pwd = 0, prd, r;
   logic [3:0] strb = 4'h3, bsel = 0, lvl = 0, plv;
   psw_class_t acls = PSW_CLS_NONE;
   logic [16:0] ares = 0;
   logic [15:0] asrc = 0, psw, sp, s0;
   logic rdy, err, e, global_irq_enable, hld, usr, mip;
   int bad_count = 0, n_tests = 0;
   // Cases: byte, class, result, overflow, source, expected E Z V C N
   localparam logic [41:0] TV [5] = '{{1'b0, 2'd0, 17'h10000, 1'b0, 16'h0000, 5'h0A},
      {1'b0, 2'd0, 17'h08000, 1'b1, 16'h8000, 5'h15}, {1'b0, 2'd1, 17'h1FFFF, 1'b1, 16'h0, 5'h01},
      {1'b1, 2'd2, 17'h00080, 1'b0, 16'h0080, 5'h11}, {1'b1, 2'd0, 17'h00100, 1'b0, 16'h0, 5'h0A}};
   always #50 clk = ~clk;
   psw_core DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pw),
      .I_PADDR(pa), .I_PWDATA(pwd), .I_PSTRB(strb), .I_BIT_WE(bwe), .I_BIT_SEL(bsel),
      .I_BIT_VAL(bval), .I_ALU_VALID(av), .I_ALU_BYTE(ab), .I_ALU_CLASS(acls),
      .I_ALU_RESULT(ares), .I_ALU_OVF(ao), .I_ALU_SRC(asrc), .I_IRQ_ENTRY(irq),
      .I_IRQ_LEVEL(lvl), .I_MULDIV_BUSY(busy), .I_RETI(reti), .I_RETI_MULDIV_INTERRUPTED_FLAG(rmul),
      .I_STK_PUSH(push), .I_STK_POP(pop), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
      .O_PSW(psw), .O_CPU_PRIORITY_LEVEL(plv), .O_GLOBAL_IRQ_ENABLE(global_irq_enable),
      .O_BUS_HOLD_ARBITRATION_ENABLE(hld), .O_USER_FLAG(usr),
      .O_MULDIV_INTERRUPTED_FLAG(mip), .O_STACK_PTR(sp));
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic summarize;
      if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One APB transfer; alu raises an implicit flag update in the access cycle
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic alu);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      pw <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      av <= alu;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (n >= 20) bad_count++;
      r = prd;
      e = err;
      psel <= 0;
      pen <= 0;
      av <= 0;
   endtask
   task automatic t_regs;
      apb(0, `PSW_BUS_ADDR, 0, 0);
      chk("reset", 32'h0, r);
      apb(1, `PSW_BUS_ADDR, 32'hFFFF, 0);
      apb(0, `PSW_BUS_ADDR, 0, 0);
      chk("word", 32'hFC7F, r);
      chk("fields", 7'h7F, {plv, global_irq_enable, hld, usr});
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         bwe <= 1;
         bsel <= i ? 4'h8 : 4'h6;
         bval <= i;
         @(posedge clk);
         bwe <= 0;
         @(posedge clk);
         chk("bit", 16'hFC3F, psw);
      end
      ares <= 0;
      acls <= PSW_CLS_ARITH;
      apb(1, `PSW_BUS_ADDR, 0, 1);
      @(posedge clk);
      chk("precedence", 16'h0, psw);
      apb(0, 32'h0000FF20, 0, 0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
   endtask
   task automatic t_alu;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         av <= 1;
         {ab, ares, ao, asrc} <= {TV[i][41], TV[i][38:5]};
         acls <= psw_class_t'(TV[i][40:39]);
         @(posedge clk);
         av <= 0;
         @(posedge clk);
         chk("flags", TV[i][4:0], psw[4:0]);
      end
   endtask
   task automatic t_irq;
      @(posedge clk);
      irq <= 1;
      lvl <= 4'hF;
      busy <= 1;
      @(posedge clk);
      irq <= 0;
      reti <= 1;
      @(posedge clk);
      chk("entry", 5'h1F, {plv, mip});
      reti <= 0;
      @(posedge clk);
      chk("reti", 1'b0, mip);
   endtask
   task automatic t_stack;
      apb(1, `PSW_STK_ADDR, 32'h10, 0);
      apb(0, `PSW_STK_ADDR, 0, 0);
      chk("size min", 32'h20, r);
      apb(1, `PSW_STK_ADDR, 32'h300, 0);
      apb(0, `PSW_STK_ADDR, 0, 0);
      chk("size max", 32'h200, r);
      apb(1, `PSW_STK_ADDR, 32'h20, 0);
      repeat (3) @(posedge clk);
      s0 = sp;
      push <= 1;
      repeat (16) @(posedge clk);
      push <= 0;
      repeat (3) @(posedge clk);
      chk("half", s0 + 16'h0010, sp);
      push <= 1;
      repeat (16) @(posedge clk);
      push <= 0;
      repeat (3) @(posedge clk);
      chk("wrap", s0, sp);
   endtask
   initial begin
      #(3000 * 100);
      bad_count++;
      summarize;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      t_regs;
      t_alu;
      t_irq;
      t_stack;
      summarize;
   end
endmodule
